// [design/mmr_dev.sv]
// memory map decoder with vector remap and the sram behind a one-entry write buffer
// assumes one request at a time: the requester waits for ack before the next req pulse
`timescale 1ns/1ps
//
// Contract
// - sram takes byte, halfword, word; lanes only
// - low address bits ignored per access size
// - sram size 2, 4 or 8 kB
// - write held, committed at next write
// - reset drops the pending write
// - requester writes twice for reset survival
// - requester dummy-writes before idle or power-down
// - peripheral areas split into 128 slots
// - peripheral registers word aligned, accessed whole; the access size is still passed to the target as given
// - vectors are eight words from zero
// - reset selects boot loader mode
// - user flash mode applies no remap
// - user ram mode maps vectors to sram
// - remap window is 64 bytes
// - remapped areas stay at home address
// - boot block fixed at top of memory
// - remote vectors hold branches, not handlers
module mmr_dev #(
    parameter int SRAM_BYTES = mmr_pkg::SRAM_MAX_BYTES
) (
    // requester side
    mmr_if.dev bus,
    // mode from system control
    input wire mmr_pkg::mmr_mode_e mode_in,
    // other targets
    output logic tgt_valid,
    output mmr_pkg::mmr_tgt_e tgt_sel,
    output logic [31:0] tgt_addr,
    output logic [mmr_pkg::SLOT_W-1:0] tgt_slot,
    output logic tgt_we,
    output mmr_pkg::mmr_size_e tgt_size,
    output logic [31:0] tgt_wdata,
    input wire logic [31:0] tgt_rdata,
    // status
    output mmr_pkg::mmr_mode_e mode_out
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef enum logic {MMR_DEV_IDLE, MMR_DEV_EXT} mmr_dev_st_e;

    typedef struct packed {
        mmr_dev_st_e st;
        mmr_pkg::mmr_mode_e mode;
        mmr_pkg::mmr_mode_e mode_seen;
        logic pend_v;
        logic [mmr_pkg::SRAM_IDX_W-1:0] pend_idx;
        logic [3:0] pend_be;
        logic [31:0] pend_data;
        logic ack;
        logic miss;
        logic [31:0] rdata;
        logic tgt_valid;
        mmr_pkg::mmr_tgt_e tgt_sel;
        logic [31:0] tgt_addr;
        logic [mmr_pkg::SLOT_W-1:0] tgt_slot;
        logic tgt_we;
        mmr_pkg::mmr_size_e tgt_size;
        logic [31:0] tgt_wdata;
    } mmr_dev_s;

    localparam logic [31:0] SRAM_LIMIT = 32'(SRAM_BYTES);
    localparam logic [mmr_pkg::SRAM_IDX_W-1:0] IDX_MASK = mmr_pkg::SRAM_IDX_W'((SRAM_BYTES / 4) - 1);

    mmr_dev_s r_reg;
    mmr_dev_s r_next;
    logic commit;
    logic [31:0] mem [mmr_pkg::SRAM_MAX_WORDS];

    // ----------------------------------------------------------------
    // decode and next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [31:0] aa;
        logic [31:0] eff;
        logic [3:0] be;
        logic [31:0] lanes;
        logic [31:0] word;
        logic [mmr_pkg::SRAM_IDX_W-1:0] idx;
        mmr_pkg::mmr_tgt_e sel;
        aa = bus.addr;
        eff = 32'h0;
        be = 4'h0;
        lanes = 32'h0;
        word = 32'h0;
        idx = '0;
        sel = mmr_pkg::MMR_TGT_NONE;
        commit = 1'b0;
        r_next = r_reg;
        r_next.ack = 1'b0;
        r_next.miss = 1'b0;
        r_next.tgt_valid = 1'b0;
        r_next.mode_seen = mode_in;
        // only a change of the input moves the mode, so a held input cannot undo reset
        if (mode_in != r_reg.mode_seen) begin
            r_next.mode = mode_in;
        end

        // natural alignment and lane selection
        case (bus.size)
            mmr_pkg::MMR_SZ_WORD: begin
                aa = {bus.addr[31:2], 2'b00};
                be = 4'hf;
                lanes = bus.wdata;
            end
            mmr_pkg::MMR_SZ_HALF: begin
                aa = {bus.addr[31:1], 1'b0};
                be = aa[1] ? 4'hc : 4'h3;
                lanes = {2{bus.wdata[15:0]}};
            end
            default: begin
                be = 4'(4'h1 << aa[1:0]);
                lanes = {4{bus.wdata[7:0]}};
            end
        endcase

        // vector window overlay; home addresses stay decoded below
        eff = aa;
        if (aa <= mmr_pkg::REMAP_LAST) begin
            case (r_reg.mode)
                mmr_pkg::MMR_MODE_BOOT: eff = mmr_pkg::BOOT_BASE | (aa & mmr_pkg::REMAP_MASK);
                mmr_pkg::MMR_MODE_RAM: eff = mmr_pkg::SRAM_BASE | (aa & mmr_pkg::REMAP_MASK);
                default: eff = aa;
            endcase
        end

        // region decode on the effective address
        if (eff[31:30] == 2'b00) begin
            sel = mmr_pkg::MMR_TGT_FLASH;
        end else if (eff[31:30] == 2'b01 && (eff - mmr_pkg::SRAM_BASE) < SRAM_LIMIT) begin
            sel = mmr_pkg::MMR_TGT_SRAM;
        end else if ((eff & ~mmr_pkg::BOOT_MASK) == mmr_pkg::BOOT_BASE) begin
            sel = mmr_pkg::MMR_TGT_BOOT;
        end else if (eff[31:mmr_pkg::AREA_LSB] == mmr_pkg::APB_BASE[31:mmr_pkg::AREA_LSB]) begin
            sel = mmr_pkg::MMR_TGT_APB;
        end else if (eff[31:mmr_pkg::AREA_LSB] == mmr_pkg::AHB_BASE[31:mmr_pkg::AREA_LSB]) begin
            sel = mmr_pkg::MMR_TGT_AHB;
        end

        idx = eff[mmr_pkg::SRAM_IDX_W+1:2] & IDX_MASK;
        // reads see the pending write so software never observes the lag
        word = mem[idx];
        if (r_reg.pend_v && r_reg.pend_idx == idx) begin
            for (int i = 0; i < 4; i++) begin
                if (r_reg.pend_be[i]) begin
                    word[8*i +: 8] = r_reg.pend_data[8*i +: 8];
                end
            end
        end

        case (r_reg.st)
            MMR_DEV_IDLE: begin
                if (bus.req) begin
                    if (sel == mmr_pkg::MMR_TGT_SRAM) begin
                        r_next.ack = 1'b1;
                        r_next.rdata = word;
                        if (bus.we) begin
                            commit = r_reg.pend_v;
                            r_next.pend_v = 1'b1;
                            r_next.pend_idx = idx;
                            r_next.pend_be = be;
                            r_next.pend_data = lanes;
                        end
                    end else if (sel == mmr_pkg::MMR_TGT_NONE) begin
                        r_next.ack = 1'b1;
                        r_next.miss = 1'b1;
                        r_next.rdata = 32'h0;
                    end else begin
                        r_next.st = MMR_DEV_EXT;
                        r_next.tgt_valid = 1'b1;
                        r_next.tgt_sel = sel;
                        r_next.tgt_addr = eff;
                        r_next.tgt_slot = eff[mmr_pkg::SLOT_LSB +: mmr_pkg::SLOT_W];
                        if (sel == mmr_pkg::MMR_TGT_APB || sel == mmr_pkg::MMR_TGT_AHB) begin
                            r_next.tgt_addr = {eff[31:2], 2'b00};
                        end
                        r_next.tgt_we = bus.we;
                        r_next.tgt_size = bus.size;
                        r_next.tgt_wdata = bus.wdata;
                    end
                end
            end
            MMR_DEV_EXT: begin
                r_next.ack = 1'b1;
                r_next.rdata = tgt_rdata;
                r_next.st = MMR_DEV_IDLE;
            end
            default: r_next.st = MMR_DEV_IDLE;
        endcase

        if (bus.rst) begin
            commit = 1'b0;
            r_next = '0;
            r_next.st = MMR_DEV_IDLE;
            r_next.mode = mmr_pkg::MMR_MODE_BOOT;
            r_next.mode_seen = mode_in;
            r_next.tgt_sel = mmr_pkg::MMR_TGT_NONE;
            r_next.tgt_size = mmr_pkg::MMR_SZ_WORD;
        end
    end

    // ----------------------------------------------------------------
    // registers and array
    // ----------------------------------------------------------------
    always_ff @(posedge bus.clk) begin
        r_reg <= r_next;
    end

    // array has no reset: only the buffered entry is lost on reset
    always_ff @(posedge bus.clk) begin
        if (commit) begin
            for (int i = 0; i < 4; i++) begin
                if (r_reg.pend_be[i]) begin
                    mem[r_reg.pend_idx][8*i +: 8] <= r_reg.pend_data[8*i +: 8];
                end
            end
        end
    end

    assign bus.ack = r_reg.ack;
    assign bus.miss = r_reg.miss;
    assign bus.rdata = r_reg.rdata;
    assign tgt_valid = r_reg.tgt_valid;
    assign tgt_sel = r_reg.tgt_sel;
    assign tgt_addr = r_reg.tgt_addr;
    assign tgt_slot = r_reg.tgt_slot;
    assign tgt_we = r_reg.tgt_we;
    assign tgt_size = r_reg.tgt_size;
    assign tgt_wdata = r_reg.tgt_wdata;
    assign mode_out = r_reg.mode;

endmodule : mmr_dev

// [design/mmr_pkg.sv]
// shared constants and types for the memory map decoder and its requester
// assumes one clock and a synchronous active-high reset on both ends
package mmr_pkg;

    // ----------------------------------------------------------------
    // address map
    // ----------------------------------------------------------------
    localparam logic [31:0] FLASH_BASE = 32'h0000_0000;
    localparam logic [31:0] SRAM_BASE = 32'h4000_0000;
    localparam logic [31:0] BOOT_BASE = 32'h7fff_e000;
    localparam logic [31:0] APB_BASE = 32'he000_0000;
    localparam logic [31:0] AHB_BASE = 32'hffe0_0000;
    localparam logic [31:0] VEC_LAST = 32'h0000_001c;
    localparam logic [31:0] REMAP_LAST = 32'h0000_003f;
    localparam logic [31:0] REMAP_MASK = 32'h0000_003f;
    localparam logic [31:0] BOOT_MASK = 32'h0000_1fff;
    localparam logic [31:0] DUMMY_ADDR = 32'h4000_07fc;

    // ----------------------------------------------------------------
    // sram geometry
    // ----------------------------------------------------------------
    localparam int SRAM_MAX_BYTES = 8192;
    localparam int SRAM_MAX_WORDS = SRAM_MAX_BYTES / 4;
    localparam int SRAM_IDX_W = 11;

    // ----------------------------------------------------------------
    // peripheral areas: 2 MB each, 128 slots of 16 kB
    // ----------------------------------------------------------------
    localparam int AREA_LSB = 21;
    localparam int SLOT_LSB = 14;
    localparam int SLOT_W = 7;
    localparam int SLOT_COUNT = 128;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {MMR_MODE_BOOT, MMR_MODE_FLASH, MMR_MODE_RAM} mmr_mode_e;
    typedef enum logic [1:0] {MMR_SZ_BYTE, MMR_SZ_HALF, MMR_SZ_WORD} mmr_size_e;
    typedef enum logic [2:0] {MMR_TGT_NONE, MMR_TGT_FLASH, MMR_TGT_BOOT, MMR_TGT_SRAM,
                              MMR_TGT_AHB, MMR_TGT_APB} mmr_tgt_e;

endpackage : mmr_pkg

// [design/mmr_if.sv]
// bus between the requester and the memory map decoder
// assumes clk and rst come from the surrounding bench or chip
`timescale 1ns/1ps
interface mmr_if (
    input wire logic clk,
    input wire logic rst
);
    logic req;
    logic we;
    logic [31:0] addr;
    mmr_pkg::mmr_size_e size;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic ack;
    logic miss;

    modport dev (input clk, input rst, input req, input we, input addr, input size, input wdata,
                 output rdata, output ack, output miss);
    modport host (input clk, input rst, output req, output we, output addr, output size, output wdata,
                  input rdata, input ack, input miss);
endinterface : mmr_if

// [design/mmr_host.sv]
// requester end: turns user commands into one-at-a-time bus requests
// assumes the decoder answers every req pulse with exactly one ack
`timescale 1ns/1ps
module mmr_host (
    // decoder side
    mmr_if.host bus,
    // command
    input wire logic cmd_valid,
    input wire logic cmd_we,
    input wire logic cmd_persist,
    input wire logic cmd_flush,
    input wire logic [31:0] cmd_addr,
    input wire mmr_pkg::mmr_size_e cmd_size,
    input wire logic [31:0] cmd_wdata,
    output logic cmd_ready,
    // response
    output logic rsp_valid,
    output logic [31:0] rsp_data,
    output logic rsp_miss
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef enum logic {MMR_HOST_IDLE, MMR_HOST_WAIT} mmr_host_st_e;

    typedef struct packed {
        mmr_host_st_e st;
        logic repeat_wr;
        logic req;
        logic we;
        logic [31:0] addr;
        mmr_pkg::mmr_size_e size;
        logic [31:0] wdata;
        logic ready;
        logic rsp_valid;
        logic [31:0] rsp_data;
        logic rsp_miss;
    } mmr_host_s;

    mmr_host_s r_reg;
    mmr_host_s r_next;

    always_comb begin
        logic [31:0] shifted;
        shifted = bus.rdata >> {r_reg.addr[1:0], 3'b000};
        // halfword lanes follow the aligned address, bit 0 is ignored
        if (r_reg.size == mmr_pkg::MMR_SZ_HALF) begin
            shifted = bus.rdata >> {r_reg.addr[1], 4'h0};
        end
        r_next = r_reg;
        r_next.req = 1'b0;
        r_next.rsp_valid = 1'b0;
        case (r_reg.st)
            MMR_HOST_IDLE: begin
                if (cmd_valid) begin
                    r_next.st = MMR_HOST_WAIT;
                    r_next.ready = 1'b0;
                    r_next.req = 1'b1;
                    if (cmd_flush) begin
                        // scratch word is sacrificed to push out the last real write
                        r_next.we = 1'b1;
                        r_next.addr = mmr_pkg::DUMMY_ADDR;
                        r_next.size = mmr_pkg::MMR_SZ_WORD;
                        r_next.wdata = 32'h0;
                        r_next.repeat_wr = 1'b0;
                    end else begin
                        r_next.we = cmd_we;
                        r_next.addr = cmd_addr;
                        r_next.size = cmd_size;
                        r_next.wdata = cmd_wdata;
                        r_next.repeat_wr = cmd_we && cmd_persist;
                        if (cmd_addr >= mmr_pkg::APB_BASE) begin
                            r_next.addr = {cmd_addr[31:2], 2'b00};
                        end
                    end
                end
            end
            MMR_HOST_WAIT: begin
                if (bus.ack) begin
                    if (r_reg.repeat_wr) begin
                        r_next.req = 1'b1;
                        r_next.repeat_wr = 1'b0;
                    end else begin
                        r_next.st = MMR_HOST_IDLE;
                        r_next.ready = 1'b1;
                        r_next.rsp_valid = 1'b1;
                        r_next.rsp_miss = bus.miss;
                        case (r_reg.size)
                            mmr_pkg::MMR_SZ_BYTE: r_next.rsp_data = {24'h0, shifted[7:0]};
                            mmr_pkg::MMR_SZ_HALF: r_next.rsp_data = {16'h0, shifted[15:0]};
                            default: r_next.rsp_data = bus.rdata;
                        endcase
                    end
                end
            end
            default: r_next.st = MMR_HOST_IDLE;
        endcase
        if (bus.rst) begin
            r_next = '0;
            r_next.st = MMR_HOST_IDLE;
            r_next.size = mmr_pkg::MMR_SZ_WORD;
            r_next.ready = 1'b1;
        end
    end

    always_ff @(posedge bus.clk) begin
        r_reg <= r_next;
    end

    assign bus.req = r_reg.req;
    assign bus.we = r_reg.we;
    assign bus.addr = r_reg.addr;
    assign bus.size = r_reg.size;
    assign bus.wdata = r_reg.wdata;
    assign cmd_ready = r_reg.ready;
    assign rsp_valid = r_reg.rsp_valid;
    assign rsp_data = r_reg.rsp_data;
    assign rsp_miss = r_reg.rsp_miss;

endmodule : mmr_host

// [bench/mmr_chk.sv]
// assertions on the requester-to-decoder bus
// assumes one instance beside the interface, signals passed by name
`timescale 1ns/1ps
module mmr_chk #(
    parameter int SRAM_BYTES = 2048
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // request
    input wire logic req,
    input wire logic we,
    input wire logic [31:0] addr,
    input wire mmr_pkg::mmr_size_e size,
    input wire logic [31:0] wdata,
    // answer
    input wire logic [31:0] rdata,
    input wire logic ack,
    input wire logic miss
);
    logic in_sram, in_periph, in_gap, wr_seen_reg;
    logic [29:0] wr_word_reg;
    logic [31:0] wr_data_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    assign in_sram = addr >= mmr_pkg::SRAM_BASE && addr < mmr_pkg::SRAM_BASE + 32'(SRAM_BYTES);
    assign in_periph = addr[31:21] == 11'h700 || addr[31:21] == 11'h7ff;
    assign in_gap = addr[31:29] == 3'b100 || (addr[31:30] == 2'b01 && !in_sram && addr < mmr_pkg::BOOT_BASE);

    // last word write to sram; any other write or a reset forgets it
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_seen_reg <= 1'b0;
        end else if (req && we) begin
            wr_seen_reg <= in_sram && size == mmr_pkg::MMR_SZ_WORD;
            wr_word_reg <= addr[31:2];
            wr_data_reg <= wdata;
        end
    end

    // ------
    // properties
    // ------
    property p_sram_fast;
        req && in_sram |=> ack && !miss;
    endproperty
    a_sram_fast: assert property (p_sram_fast)
        else $error("sram request not answered next cycle");
    property p_gap;
        req && in_gap |=> ack && miss && rdata == 32'h0;
    endproperty
    a_gap: assert property (p_gap)
        else $error("unmapped address not answered as miss");
    property p_periph;
        req && in_periph |=> !ack ##1 (ack && !miss);
    endproperty
    a_periph: assert property (p_periph)
        else $error("peripheral slot access latency wrong");
    property p_boot;
        req && addr >= mmr_pkg::BOOT_BASE && !addr[31] |-> ##2 (ack && !miss);
    endproperty
    a_boot: assert property (p_boot)
        else $error("boot block not decoded at its fixed place");
    property p_flash;
        req && addr[31:30] == 2'b00 && addr[31:6] != 26'h0 |=> !ack ##1 (ack && !miss);
    endproperty
    a_flash: assert property (p_flash)
        else $error("flash above the vector window misdecoded");
    property p_align;
        req && addr >= 32'he000_0000 |-> addr[1:0] == 2'b00;
    endproperty
    a_align: assert property (p_align)
        else $error("peripheral request not word aligned");
    property p_fwd;
        req && !we && wr_seen_reg && addr[31:2] == wr_word_reg |=> ack && rdata == wr_data_reg;
    endproperty
    a_fwd: assert property (p_fwd)
        else $error("read of written word returned other data");
    property p_hold;
        !ack |-> $stable(rdata);
    endproperty
    a_hold: assert property (p_hold)
        else $error("read data moved without ack");
    property p_cause;
        ack |-> $past(req) || $past(req, 2);
    endproperty
    a_cause: assert property (p_cause)
        else $error("ack without a recent request");
endmodule : mmr_chk

// [bench/memory_map_remap_sram_tb.sv]
// bench: decoder and requester joined by the bus, user sides driven here
// assumes package, interface and both ends compiled before this file
`timescale 1ns/1ps
module memory_map_remap_sram_tb;
    localparam int SRAM_BYTES = 2048;
    localparam logic [31:0] KEY = 32'h5a5a_0f0f;
    localparam mmr_pkg::mmr_size_e SB = mmr_pkg::MMR_SZ_BYTE;
    localparam mmr_pkg::mmr_size_e SH = mmr_pkg::MMR_SZ_HALF;
    localparam mmr_pkg::mmr_size_e SW = mmr_pkg::MMR_SZ_WORD;
    logic clk, rst, cmd_valid, cmd_we, cmd_persist, cmd_flush, cmd_ready, rsp_valid, rsp_miss;
    logic [31:0] cmd_addr, cmd_wdata, rsp_data, tgt_addr, tgt_wdata, tgt_rdata, seen_addr, seen_wdata;
    logic tgt_valid, tgt_we, seen_we;
    logic [6:0] tgt_slot, seen_slot;
    mmr_pkg::mmr_size_e cmd_size, tgt_size, seen_size;
    mmr_pkg::mmr_mode_e mode_in, mode_out;
    mmr_pkg::mmr_tgt_e tgt_sel, seen_sel;
    int failures, total_checks;

    mmr_if bus (.clk(clk), .rst(rst));
    mmr_host i_mmr_host (.bus(bus.host), .cmd_valid(cmd_valid), .cmd_we(cmd_we), .cmd_persist(cmd_persist),
        .cmd_flush(cmd_flush), .cmd_addr(cmd_addr), .cmd_size(cmd_size), .cmd_wdata(cmd_wdata),
        .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_miss(rsp_miss));
    mmr_dev #(.SRAM_BYTES(SRAM_BYTES)) i_mmr_dev (.bus(bus.dev), .mode_in(mode_in), .tgt_valid(tgt_valid),
        .tgt_sel(tgt_sel), .tgt_addr(tgt_addr), .tgt_slot(tgt_slot), .tgt_we(tgt_we), .tgt_size(tgt_size),
        .tgt_wdata(tgt_wdata), .tgt_rdata(tgt_rdata), .mode_out(mode_out));
    mmr_chk #(.SRAM_BYTES(SRAM_BYTES)) i_mmr_chk (.clk(clk), .rst(rst), .req(bus.req), .we(bus.we),
        .addr(bus.addr), .size(bus.size), .wdata(bus.wdata), .rdata(bus.rdata), .ack(bus.ack), .miss(bus.miss));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // far-side target: answers from its address, scrambles the line otherwise
    always @(negedge clk) tgt_rdata <= tgt_valid ? tgt_addr ^ KEY : ~tgt_rdata;
    always @(posedge clk) begin
        if (tgt_valid) begin
            seen_sel <= tgt_sel;
            seen_addr <= tgt_addr;
            seen_slot <= tgt_slot;
            seen_we <= tgt_we;
            seen_size <= tgt_size;
            seen_wdata <= tgt_wdata;
        end
    end

    // ------
    // checks and bus tasks
    // ------
    task automatic complete_run();
        if (failures == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run
    task automatic bad(input string s);
        failures++;
        $display("[ERR] %0t %s", $time, s);
    endtask : bad
    task automatic check_data(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) bad($sformatf("data %h expected %h", got, exp));
    endtask : check_data
    task automatic check_bit(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) bad($sformatf("flag %b expected %b", got, exp));
    endtask : check_bit
    task automatic check_sel(input mmr_pkg::mmr_tgt_e got, input mmr_pkg::mmr_tgt_e exp);
        total_checks++;
        if (got !== exp) bad($sformatf("target %0d expected %0d", got, exp));
    endtask : check_sel
    task automatic check_mode(input mmr_pkg::mmr_mode_e got, input mmr_pkg::mmr_mode_e exp);
        total_checks++;
        if (got !== exp) bad($sformatf("mode %0d expected %0d", got, exp));
    endtask : check_mode
    // entered and left at a falling edge
    task automatic do_cmd(input logic we, input logic pers, input logic fl, input logic [31:0] a,
                          input mmr_pkg::mmr_size_e sz, input logic [31:0] d);
        int n;
        {cmd_we, cmd_persist, cmd_flush, cmd_addr, cmd_wdata} = {we, pers, fl, a, d};
        cmd_size = sz;
        cmd_valid = 1'b1;
        @(negedge clk);
        cmd_valid = 1'b0;
        check_bit(cmd_ready, 1'b0);
        n = 0;
        while (rsp_valid !== 1'b1) begin
            if (n++ > 20) begin
                bad("no response");
                complete_run();
            end
            @(negedge clk);
        end
    endtask : do_cmd
    task automatic rd_chk(input logic [31:0] a, input mmr_pkg::mmr_size_e sz, input logic [31:0] e, input logic m);
        do_cmd(1'b0, 1'b0, 1'b0, a, sz, 32'h0);
        check_data(rsp_data, e);
        check_bit(rsp_miss, m);
    endtask : rd_chk
    task automatic rd_ext(input logic [31:0] a, input logic [31:0] eff, input mmr_pkg::mmr_tgt_e sel);
        seen_sel = mmr_pkg::MMR_TGT_NONE;
        rd_chk(a, SW, eff ^ KEY, 1'b0);
        check_sel(seen_sel, sel);
        check_data(seen_addr, eff);
    endtask : rd_ext
    task automatic do_reset();
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        check_mode(mode_out, mmr_pkg::MMR_MODE_BOOT);
        repeat (2) @(negedge clk);
        check_mode(mode_out, mmr_pkg::MMR_MODE_BOOT);
    endtask : do_reset
    task automatic set_mode(input mmr_pkg::mmr_mode_e m);
        mode_in = m;
        repeat (2) @(negedge clk);
        check_mode(mode_out, m);
    endtask : set_mode

    // ------
    // scenarios
    // ------
    task automatic t_lanes();
        do_cmd(1'b1, 1'b0, 1'b0, 32'h4000_0010, SW, 32'h1122_3344);
        do_cmd(1'b1, 1'b0, 1'b0, 32'h4000_0011, SB, 32'h0000_00ab);
        do_cmd(1'b1, 1'b0, 1'b0, 32'h4000_0013, SH, 32'h0000_cdef);
        do_cmd(1'b1, 1'b0, 1'b0, 32'h4000_0016, SW, 32'hdead_beef);
        rd_chk(32'h4000_0012, SW, 32'hcdef_ab44, 1'b0);
        rd_chk(32'h4000_0011, SB, 32'h0000_00ab, 1'b0);
        rd_chk(32'h4000_0013, SH, 32'h0000_cdef, 1'b0);
        rd_chk(32'h4000_0014, SW, 32'hdead_beef, 1'b0);
        rd_chk(32'h4000_0800, SW, 32'h0, 1'b1);
    endtask : t_lanes
    task automatic t_remap();
        do_cmd(1'b1, 1'b0, 1'b0, 32'h4000_001c, SW, 32'h5eed_001c);
        do_cmd(1'b1, 1'b0, 1'b0, 32'h4000_003c, SW, 32'h5eed_003c);
        set_mode(mmr_pkg::MMR_MODE_BOOT);
        rd_ext(32'h1c, 32'h7fff_e01c, mmr_pkg::MMR_TGT_BOOT);
        rd_ext(32'h3c, 32'h7fff_e03c, mmr_pkg::MMR_TGT_BOOT);
        rd_ext(32'h40, 32'h40, mmr_pkg::MMR_TGT_FLASH);
        rd_ext(32'h7fff_e01c, 32'h7fff_e01c, mmr_pkg::MMR_TGT_BOOT);
        set_mode(mmr_pkg::MMR_MODE_FLASH);
        rd_ext(32'h1c, 32'h1c, mmr_pkg::MMR_TGT_FLASH);
        set_mode(mmr_pkg::MMR_MODE_RAM);
        rd_chk(32'h1c, SW, 32'h5eed_001c, 1'b0);
        rd_chk(32'h3f, SB, 32'h0000_005e, 1'b0);
        rd_ext(32'h40, 32'h40, mmr_pkg::MMR_TGT_FLASH);
        rd_chk(32'h4000_001c, SW, 32'h5eed_001c, 1'b0);
        rd_ext(32'h7fff_fffc, 32'h7fff_fffc, mmr_pkg::MMR_TGT_BOOT);
    endtask : t_remap
    task automatic t_periph();
        rd_ext(32'he01f_c140, 32'he01f_c140, mmr_pkg::MMR_TGT_APB);
        check_data({25'h0, seen_slot}, 32'h7f);
        rd_ext(32'hffe0_4004, 32'hffe0_4004, mmr_pkg::MMR_TGT_AHB);
        check_data({25'h0, seen_slot}, 32'h1);
        rd_ext(32'he000_4003, 32'he000_4000, mmr_pkg::MMR_TGT_APB);
        seen_sel = mmr_pkg::MMR_TGT_NONE;
        do_cmd(1'b1, 1'b0, 1'b0, 32'he002_8002, SH, 32'h0000_1234);
        check_bit(rsp_miss, 1'b0);
        check_sel(seen_sel, mmr_pkg::MMR_TGT_APB);
        check_data(seen_addr, 32'he002_8000);
        check_data(seen_wdata, 32'h0000_1234);
        check_bit(seen_we, 1'b1);
        check_data(32'(seen_size), 32'(mmr_pkg::MMR_SZ_HALF));
        rd_chk(32'he020_0000, SW, 32'h0, 1'b1);
        rd_chk(32'h9000_0000, SW, 32'h0, 1'b1);
    endtask : t_periph
    task automatic t_reset();
        do_cmd(1'b1, 1'b0, 1'b0, 32'h4000_0100, SW, 32'h0);
        do_cmd(1'b1, 1'b0, 1'b0, 32'h4000_0104, SW, 32'h0);
        do_cmd(1'b0, 1'b0, 1'b1, 32'h0, SW, 32'h0);
        do_cmd(1'b1, 1'b1, 1'b0, 32'h4000_0100, SW, 32'hc0c0_c0c0);
        do_cmd(1'b1, 1'b0, 1'b0, 32'h4000_0104, SW, 32'hd0d0_d0d0);
        do_reset();
        rd_chk(32'h4000_0100, SW, 32'hc0c0_c0c0, 1'b0);
        rd_chk(32'h4000_0104, SW, 32'h0, 1'b0);
        rd_ext(32'h1c, 32'h7fff_e01c, mmr_pkg::MMR_TGT_BOOT);
        do_cmd(1'b1, 1'b0, 1'b0, 32'h4000_0104, SW, 32'hd1d1_d1d1);
        do_cmd(1'b0, 1'b0, 1'b1, 32'h0, SW, 32'h0);
        do_reset();
        rd_chk(32'h4000_0104, SW, 32'hd1d1_d1d1, 1'b0);
    endtask : t_reset

    initial begin
        {rst, cmd_valid, cmd_we, cmd_persist, cmd_flush, cmd_addr, cmd_wdata} = {3'b100, 2'b00, 64'h0};
        cmd_size = SW;
        mode_in = mmr_pkg::MMR_MODE_RAM;
        failures = 0;
        total_checks = 0;
        repeat (8) @(negedge clk);
        rst = 1'b0;
        check_mode(mode_out, mmr_pkg::MMR_MODE_BOOT);
        repeat (2) @(negedge clk);
        check_mode(mode_out, mmr_pkg::MMR_MODE_BOOT);
        t_lanes();
        t_remap();
        t_periph();
        t_reset();
        complete_run();
    end
endmodule : memory_map_remap_sram_tb
